// >>> dv/adv_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "adv_timer_regs.svh"

// Watches timing relations between the timer controls and its results.
module adv_timer_monitor
	import adv_timer_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Controls.
	input wire cnt_mode_t cnt_mode,
	input wire slave_mode_t slave_mode,
	input wire logic sw_update,
	input wire logic moe_set,
	input wire logic brk_pin,
	input wire logic brk_known_state,
	input wire logic [`CNT_W-1:0] adc_pos,
	// Results.
	input wire logic [`NCH-1:0] pwm_oe,
	input wire logic [`NCP-1:0] pwmn_oe,
	input wire logic upd_evt,
	input wire logic link_trig_out,
	input wire logic brk_evt,
	input wire logic adc_trig,
	input wire logic [`CNT_W-1:0] cnt_value,
	input wire logic moe_state
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Break held long enough to pass the pin synchroniser.
	sequence brk_held;
		brk_pin [*4];
	endsequence
	a_sw_upd_event: assert property (
		sw_update |=> upd_evt && link_trig_out)
		else $error("No update event after software update.");
	a_sw_cnt_reinit: assert property (
		sw_update && cnt_mode == CM_UP && slave_mode == SM_OFF
		|=> cnt_value == `CNT_ZERO)
		else $error("Counter not cleared by software update.");
	a_moe_arm: assert property (
		!brk_pin [*4] ##0 moe_set |=> moe_state)
		else $error("Output enable not armed.");
	a_brk_moe_drop: assert property (
		brk_held |=> !moe_state)
		else $error("Break did not drop output enable.");
	a_brk_release: assert property (
		brk_held ##1 brk_pin && !brk_known_state
		|=> pwm_oe == '0 && pwmn_oe == '0)
		else $error("Break did not release the outputs.");
	a_brk_event: assert property (
		$rose(brk_pin) |-> ##[3:5] brk_evt)
		else $error("No break event.");
	a_adc_place: assert property (
		adc_trig |-> $past(cnt_value) == $past(adc_pos))
		else $error("Converter trigger at wrong count.");
	a_up_step: assert property (
		cnt_mode == CM_UP && slave_mode == SM_OFF && $stable(cnt_mode)
		&& $stable(slave_mode) && !$past(sw_update) && $changed(cnt_value)
		|-> cnt_value == $past(cnt_value) + `CNT_ONE
		|| cnt_value == `CNT_ZERO)
		else $error("Up count skipped a value.");
endmodule

bind advanced_control_timer adv_timer_monitor mon (
	.clk_sys, .rst_n, .cnt_mode, .slave_mode, .sw_update, .moe_set,
	.brk_pin, .brk_known_state, .adc_pos, .pwm_oe, .pwmn_oe, .upd_evt,
	.link_trig_out, .brk_evt, .adc_trig, .cnt_value, .moe_state);

`default_nettype wire

// >>> dv/advanced_control_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "adv_timer_regs.svh"

// Drives the timer through its pins and checks the results.
module advanced_control_timer_test
	import adv_timer_pkg::*;
;
	// Stimulus.
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	cnt_mode_t cnt_mode = CM_UP;
	slave_mode_t slave_mode = SM_OFF;
	ch_mode_t ch_mode [`NCH] = '{CH_PWM, CH_CAPTURE, CH_COMPARE, CH_PWM};
	logic [`NCH-1:0][`CNT_W-1:0] ch_val = {4{16'h0004}};
	logic [`CNT_W-1:0] psc_val = 16'h0000;
	logic [`CNT_W-1:0] arr_val = 16'h0009;
	logic [`CNT_W-1:0] adc_pos = 16'h0002;
	logic [`REP_W-1:0] rep_val = 8'h00;
	logic [`DT_W-1:0] dead_time = 8'h02;
	logic [7:0] cmd = 8'h00; // One pulse bit per command.
	logic trig_sel_link = 1'b1;
	logic brk_known_state = 1'b0;
	logic [`NCH-1:0] idle_lvl = 4'h5;
	logic dbg_halt = 1'b0;
	logic dbg_freeze_en = 1'b1;
	logic [`NCH-1:0] ch_pin = 4'h0;
	logic brk_pin = 1'b0;
	logic ref_clear_en = 1'b0;
	// Sensor lines and results.
	logic enc_a, enc_b, upd_evt, trg_evt, brk_evt, adc_trig, moe_state;
	logic [`HALL_W-1:0] hall;
	logic [`NCH-1:0] pwm_out, pwm_oe, cc_evt;
	logic [`NCP-1:0] pwmn_out, pwmn_oe;
	logic [`CNT_W-1:0] cnt_value;
	logic [`NCH-1:0][`CNT_W-1:0] cap_val;
	wire logic [7:0] evts = {adc_trig, cc_evt, brk_evt, trg_evt, upd_evt};
	int fail_count = 0;
	int compares = 0;
	int waited, np, nn, nb;
	// Reload, prescale, repetition, mode, expected update spacing.
	int tab [5][5] = '{'{2, 0, 0, 0, 3}, '{4, 1, 0, 0, 10},
		'{3, 0, 2, 0, 12}, '{4, 0, 0, 1, 5}, '{4, 0, 1, 2, 8}};

	motor_side_model partner (.clk_sys, .rst_n, .enc_fwd(cmd[5]),
		.enc_rev(cmd[6]), .hall_step(cmd[7]), .enc_a, .enc_b, .hall);
	advanced_control_timer dut (.clk_sys, .rst_n, .cnt_mode, .psc_val,
		.arr_val, .rep_val, .preload_en(1'b1), .one_pulse(1'b0),
		.cnt_start(cmd[0]), .cnt_stop(cmd[1]), .sw_update(cmd[2]),
		.slave_mode, .trig_sel_link, .link_trig_in(cmd[4]),
		.ref_clear_en, .ch_mode, .ch_val, .dead_time,
		.moe_set(cmd[3]), .brk_known_state, .idle_lvl, .idle_lvl_n(3'h0),
		.adc_pos, .dbg_halt, .dbg_freeze_en, .ch_pin, .brk_pin,
		.trig_pin(1'b0), .enc_a_pin(enc_a), .enc_b_pin(enc_b),
		.hall_pin(hall), .pwm_out, .pwm_oe, .pwmn_out, .pwmn_oe, .upd_evt,
		.trg_evt, .brk_evt, .cc_evt, .adc_trig, .link_trig_out(),
		.cnt_value, .cap_val, .moe_state);

	always #5 clk_sys = ~clk_sys;

	// Counts one comparison and reports a mismatch.
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// Raises one command bit for a single clock.
	task automatic pulse(input int b);
		@(negedge clk_sys);
		cmd[b] = 1'b1;
		@(negedge clk_sys);
		cmd[b] = 1'b0;
	endtask
	// Waits a bounded time for one event bit.
	task automatic wait_evt(input int b, input int lim);
		waited = 0;
		while (evts[b] !== 1'b1 && waited < lim) begin
			@(negedge clk_sys);
			waited++;
		end
		check("event", evts[b], 1'b1);
	endtask
	// Times the spacing of update events once settled.
	task automatic period(input int exp);
		repeat (4) begin
			@(negedge clk_sys);
			wait_evt(0, 2000);
		end
		check("period", waited + 1, exp);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic test_done;
		$display("Compares %0d, failures %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		test_done();
	end

	// Main sequence of scenarios.
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		@(negedge clk_sys);
		check("count at reset", cnt_value, 32'h0);
		check("outputs at reset", {moe_state, pwm_oe}, 32'h0);
		pulse(0);
		// The reload shadow holds its reset value until an update loads it.
		pulse(2);
		// Update spacing for every counting mode, two prescales and three repetition counts.
		for (int i = 0; i < 5; i++) begin
			arr_val = 16'(tab[i][0]);
			psc_val = 16'(tab[i][1]);
			rep_val = 8'(tab[i][2]);
			cnt_mode = cnt_mode_t'(tab[i][3]);
			period(tab[i][4]);
		end
		// Software reinitialisation during a slow count.
		cnt_mode = CM_UP;
		arr_val = 16'h0009;
		psc_val = 16'h0009;
		rep_val = 8'h00;
		period(100);
		pulse(2);
		check("sw update event", upd_evt, 1'b1);
		check("sw update count", cnt_value, 32'h0);
		// Complementary pair with dead time over two periods.
		psc_val = 16'h0000;
		period(10);
		pulse(3);
		repeat (4) @(negedge clk_sys);
		np = 0;
		nn = 0;
		nb = 0;
		repeat (20) begin
			@(negedge clk_sys);
			np += pwm_out[0];
			nn += pwmn_out[0];
			nb += pwm_out[0] & pwmn_out[0];
		end
		check("main high", np, 4);
		check("comp high", nn, 8);
		check("both high", nb, 0);
		check("main enable", pwm_oe[0], 1'b1);
		// A high trigger clears the reference until the next update.
		wait_evt(0, 20);
		ref_clear_en = 1'b1;
		pulse(4);
		repeat (4) @(negedge clk_sys);
		check("limit pair", {pwm_out[0], pwmn_out[0]}, 2'h1);
		ref_clear_en = 1'b0;
		wait_evt(5, 30);
		wait_evt(7, 30);
		// Break releases the pins, then drives the idle levels.
		for (int k = 0; k < 2; k++) begin
			brk_known_state = k[0];
			brk_pin = 1'b1;
			wait_evt(2, 10);
			repeat (3) @(negedge clk_sys);
			pulse(3);
			check("arm in break", moe_state, 1'b0);
			check("safe pin", {pwm_oe[0], pwm_out[0]}, {k[0], k[0]});
			brk_pin = 1'b0;
			repeat (5) @(negedge clk_sys);
			pulse(3);
			check("rearm", moe_state, 1'b1);
		end
		// Debug halt turns the switches off.
		brk_known_state = 1'b0;
		dbg_halt = 1'b1;
		repeat (5) @(negedge clk_sys);
		check("halt outputs", pwm_oe[0], 1'b0);
		dbg_halt = 1'b0;
		// A linked timer reinitialises the counter.
		slave_mode = SM_RESET;
		pulse(4);
		wait_evt(1, 6);
		// Rising trigger edges clock the counter in external clock mode.
		slave_mode = SM_EXTCLK;
		np = cnt_value;
		repeat (3) pulse(4);
		check("ext clock", cnt_value, (np + 3) % (arr_val + 1));
		// Encoder steps five forward and two back, then a capture.
		arr_val = 16'h00FF;
		slave_mode = SM_ENCODER;
		pulse(2);
		for (int s = 0; s < 7; s++) begin
			pulse(s < 5 ? 5 : 6);
			repeat (4) @(negedge clk_sys);
			if (s == 4) check("encoder up", cnt_value, 32'h5);
		end
		check("encoder down", cnt_value, 32'h3);
		ch_pin[1] = 1'b1;
		wait_evt(4, 8);
		@(negedge clk_sys);
		check("capture", cap_val[1], 32'h3);
		ch_pin[1] = 1'b0;
		// A Hall code change reinitialises the counter.
		psc_val = 16'hFFFF;
		slave_mode = SM_HALL;
		repeat (2) @(negedge clk_sys);
		pulse(7);
		wait_evt(1, 8);
		check("hall count", cnt_value, 32'h0);
		test_done();
	end
endmodule

`default_nettype wire

// >>> dv/motor_side_model.sv
`timescale 1ns/1ps
`default_nettype none

// Quadrature encoder and Hall sensors on the motor shaft.
module motor_side_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Step requests.
	input wire logic enc_fwd,
	input wire logic enc_rev,
	input wire logic hall_step,
	// Sensor lines.
	output logic enc_a,
	output logic enc_b,
	output logic [2:0] hall
);
	logic [1:0] phase_r; // Quadrature phase.
	logic [2:0] john_r; // Johnson count behind the Hall code.
	// A leads B when moving forward; one line changes per step.
	assign enc_a = phase_r[1] ^ phase_r[0];
	assign enc_b = phase_r[1];
	// The mask keeps the code off all-zero and all-one.
	assign hall = john_r ^ 3'h2;
	// Shaft position moves on request.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 2'h0;
			john_r <= 3'h0;
		end else begin
			phase_r <= phase_r + {enc_rev, enc_fwd | enc_rev};
			if (hall_step) begin
				john_r <= {john_r[1:0], ~john_r[2]};
			end
		end
	end
endmodule

`default_nettype wire

// >>> hdl/adv_timer_pkg.sv
package adv_timer_pkg;

	// Counting direction and alignment.
	typedef enum logic [1:0] {CM_UP, CM_DOWN, CM_CENTER} cnt_mode_t;

	// How the trigger input steers the counter.
	typedef enum logic [2:0] {
		SM_OFF, SM_RESET, SM_GATED, SM_TRIGGER, SM_EXTCLK, SM_ENCODER, SM_HALL
	} slave_mode_t;

	// Function of one channel.
	typedef enum logic [1:0] {CH_CAPTURE, CH_COMPARE, CH_PWM} ch_mode_t;

endpackage

// >>> hdl/adv_timer_regs.svh
`ifndef ADV_TIMER_REGS_SVH
`define ADV_TIMER_REGS_SVH

// Counter, repetition and dead-time widths.
`define CNT_W 16
`define REP_W 8
`define DT_W 8
// Channel counts: all channels, and those with a complementary pair.
`define NCH 4
`define NCP 3
`define HALL_W 3
// Layout of the synchronised pin vector.
`define SYNC_W 11
`define SY_CH 0
`define SY_BRK 4
`define SY_TRG 5
`define SY_ENA 6
`define SY_ENB 7
`define SY_HALL 8
// Shifts a pin sample needs before its edge history can be trusted.
`define HIST_W 3
// Reset and boundary values.
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define PSC_RST 16'h0000
`define ARR_RST 16'hFFFF
`define REP_ZERO 8'h00
`define REP_ONE 8'h01
`define DT_ZERO 8'h00
`define DT_ONE 8'h01
// Highest kernel clock the timing is meant for, in MHz.
`define KCLK_MAX_MHZ 48

`endif

// >>> hdl/advanced_control_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adv_timer_regs.svh"

module advanced_control_timer
	import adv_timer_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Counter configuration and commands.
	input wire cnt_mode_t cnt_mode,
	input wire logic [`CNT_W-1:0] psc_val,
	input wire logic [`CNT_W-1:0] arr_val,
	input wire logic [`REP_W-1:0] rep_val,
	input wire logic preload_en,
	input wire logic one_pulse,
	input wire logic cnt_start,
	input wire logic cnt_stop,
	input wire logic sw_update,
	// Slave control and timer link.
	input wire slave_mode_t slave_mode,
	input wire logic trig_sel_link,
	input wire logic link_trig_in,
	input wire logic ref_clear_en,
	// Channel configuration.
	input wire ch_mode_t ch_mode [`NCH],
	input wire logic [`NCH-1:0][`CNT_W-1:0] ch_val,
	// Output stage configuration.
	input wire logic [`DT_W-1:0] dead_time,
	input wire logic moe_set,
	input wire logic brk_known_state,
	input wire logic [`NCH-1:0] idle_lvl,
	input wire logic [`NCP-1:0] idle_lvl_n,
	input wire logic [`CNT_W-1:0] adc_pos,
	// Debug control.
	input wire logic dbg_halt,
	input wire logic dbg_freeze_en,
	// Pins from outside.
	input wire logic [`NCH-1:0] ch_pin,
	input wire logic brk_pin,
	input wire logic trig_pin,
	input wire logic enc_a_pin,
	input wire logic enc_b_pin,
	input wire logic [`HALL_W-1:0] hall_pin,
	// Pins to the power stage.
	output logic [`NCH-1:0] pwm_out,
	output logic [`NCH-1:0] pwm_oe,
	output logic [`NCP-1:0] pwmn_out,
	output logic [`NCP-1:0] pwmn_oe,
	// Event requests and link output.
	output logic upd_evt,
	output logic trg_evt,
	output logic brk_evt,
	output logic [`NCH-1:0] cc_evt,
	output logic adc_trig,
	output logic link_trig_out,
	// Status.
	output logic [`CNT_W-1:0] cnt_value,
	output logic [`NCH-1:0][`CNT_W-1:0] cap_val,
	output logic moe_state
);

	// Rising edge of a sampled level.
	function automatic logic rose(input logic cur, input logic old);
		return cur & ~old;
	endfunction

	logic [`SYNC_W-1:0] pins_in; // All outside pins, packed.
	logic [`SYNC_W-1:0] sync1_r; // First synchroniser stage.
	logic [`SYNC_W-1:0] sync2_r; // Second stage, safe to use.
	logic [`SYNC_W-1:0] prev_r; // Second stage one cycle later.
	logic [`HIST_W-1:0] warm_r; // Fills with ones as the stages fill.
	logic [`SYNC_W-1:0] hist; // Edge history, equal to now until filled.
	logic [`NCH-1:0] ch_s; // Synchronised capture inputs.
	logic [`NCH-1:0] ch_p; // Their previous value.
	logic [`HALL_W-1:0] hall_s; // Synchronised Hall lines.
	logic [`HALL_W-1:0] hall_p; // Their previous value.
	logic brk_s; // Synchronised break.
	logic trig_lvl; // Selected trigger level.
	logic trig_prev_r; // Trigger level one cycle ago.
	logic trig_rise; // Trigger rising edge.
	logic trig_edge; // Any trigger edge.
	logic enc_step; // One quadrature step.
	logic enc_up; // Direction of that step.
	logic hall_chg; // Hall pattern changed.
	logic halted; // Debug freeze active.
	logic clk_pulse; // Counter clock source pulse.
	logic psc_done; // Prescaler at terminal count.
	logic tick; // Counter advances this cycle.
	logic reinit; // Counter reinitialised this cycle.
	logic wrap; // Overflow or underflow.
	logic upd_now; // Update event this cycle.
	logic run_r; // Counter enabled.
	logic [`CNT_W-1:0] psc_cnt_r; // Prescaler count.
	logic [`CNT_W-1:0] psc_sh_r; // Prescaler value in use.
	logic [`CNT_W-1:0] arr_sh_r; // Reload value in use.
	logic [`REP_W-1:0] rep_cnt_r; // Periods left before an update.
	logic [`CNT_W-1:0] cnt_r, cnt_nxt; // Main counter.
	logic dir_r, dir_nxt; // High while counting down.
	logic clr_r; // Reference cleared until next update.
	logic moe_r; // Main output enable.
	logic out_live; // Outputs follow the waveform.
	logic [`NCH-1:0] ocref_r; // Channel reference waveforms.
	logic [`NCH-1:0] ref_eff; // References after clearing.
	logic [`NCP-1:0] dt_p; // Dead-time main outputs.
	logic [`NCP-1:0] dt_n; // Dead-time complementary outputs.

	assign pins_in = {hall_pin, enc_b_pin, enc_a_pin, trig_pin, brk_pin, ch_pin};

	// Two-stage synchroniser for every pin, plus an edge history stage.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
			warm_r <= '0;
		end else begin
			sync1_r <= pins_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
			warm_r <= {warm_r[`HIST_W-2:0], 1'b1};
		end
	end

	assign ch_s = sync2_r[`SY_CH +: `NCH];
	// Until real samples fill the stages the history mirrors the present,
	// so a pin other than the trigger pin that idles high gives no false edge after reset.
	assign hist = (&warm_r) ? prev_r : sync2_r;
	assign ch_p = hist[`SY_CH +: `NCH];
	assign hall_s = sync2_r[`SY_HALL +: `HALL_W];
	assign hall_p = hist[`SY_HALL +: `HALL_W];
	assign brk_s = sync2_r[`SY_BRK];

	// The link input comes from a timer on this clock, so it is not resynced.
	assign trig_lvl = trig_sel_link ? link_trig_in : sync2_r[`SY_TRG];
	assign trig_rise = rose(trig_lvl, trig_prev_r);
	assign trig_edge = trig_lvl ^ trig_prev_r;

	// Trigger history.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trig_prev_r <= 1'b0;
		end else begin
			trig_prev_r <= trig_lvl;
		end
	end

	// Quadrature decode counts every edge of either line.
	assign enc_step = (sync2_r[`SY_ENA] ^ hist[`SY_ENA]) |
		(sync2_r[`SY_ENB] ^ hist[`SY_ENB]);
	assign enc_up = sync2_r[`SY_ENA] ^ prev_r[`SY_ENB];
	assign hall_chg = (slave_mode == SM_HALL) && (hall_s != hall_p);

	assign halted = dbg_halt & dbg_freeze_en;

	// Source of counter clock pulses before the prescaler.
	always_comb begin
		case (slave_mode)
			SM_EXTCLK: clk_pulse = trig_rise;
			SM_ENCODER: clk_pulse = enc_step;
			SM_GATED: clk_pulse = trig_lvl;
			default: clk_pulse = 1'b1;
		endcase
	end

	assign psc_done = (psc_cnt_r == psc_sh_r);
	// The timing assumes a kernel clock of at most KCLK_MAX_MHZ.
	assign tick = run_r & clk_pulse & psc_done & ~halted;
	assign reinit = sw_update | hall_chg |
		((slave_mode == SM_RESET) & trig_rise);

	// Prescaler: divides by psc_sh_r + 1, restarts on every update.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			psc_cnt_r <= `PSC_RST;
		end else if (upd_now || (psc_done && clk_pulse && !halted)) begin
			psc_cnt_r <= `PSC_RST;
		end else if (clk_pulse && run_r && !halted) begin
			psc_cnt_r <= psc_cnt_r + `CNT_ONE;
		end
	end

	// The prescaler shadow changes only at an update; the reload shadow also follows arr_val every cycle while preload_en is low.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			psc_sh_r <= `PSC_RST;
			arr_sh_r <= `ARR_RST;
		end else begin
			if (upd_now) begin
				psc_sh_r <= psc_val;
			end
			if (upd_now || !preload_en) begin
				arr_sh_r <= arr_val;
			end
		end
	end

	// Next counter value and whether the period wrapped.
	always_comb begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		wrap = 1'b0;
		if (reinit) begin
			dir_nxt = (cnt_mode == CM_DOWN);
			cnt_nxt = (cnt_mode == CM_DOWN) ? arr_sh_r : `CNT_ZERO;
		end else if (tick && slave_mode == SM_ENCODER) begin
			if (enc_up) begin
				cnt_nxt = (cnt_r >= arr_sh_r) ? `CNT_ZERO : cnt_r + `CNT_ONE;
			end else begin
				cnt_nxt = (cnt_r == `CNT_ZERO) ? arr_sh_r : cnt_r - `CNT_ONE;
			end
		end else if (tick) begin
			case (cnt_mode)
				CM_UP: begin
					wrap = (cnt_r >= arr_sh_r);
					cnt_nxt = wrap ? `CNT_ZERO : cnt_r + `CNT_ONE;
				end
				CM_DOWN: begin
					wrap = (cnt_r == `CNT_ZERO);
					cnt_nxt = wrap ? arr_sh_r : cnt_r - `CNT_ONE;
				end
				CM_CENTER: begin
					if (!dir_r && cnt_r >= arr_sh_r) begin
						wrap = 1'b1;
						dir_nxt = 1'b1;
						cnt_nxt = cnt_r - `CNT_ONE;
					end else if (dir_r && cnt_r == `CNT_ZERO) begin
						wrap = 1'b1;
						dir_nxt = 1'b0;
						cnt_nxt = `CNT_ONE;
					end else begin
						cnt_nxt = dir_r ? cnt_r - `CNT_ONE : cnt_r + `CNT_ONE;
					end
				end
				default: cnt_nxt = cnt_r;
			endcase
		end
	end

	// An update fires on the wrap that finds the repetition count empty.
	assign upd_now = (wrap && rep_cnt_r == `REP_ZERO) || reinit;

	// Counter and direction; every instance keeps its own copy.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= `CNT_ZERO;
			dir_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			dir_r <= dir_nxt;
		end
	end

	// Repetition counter reloads on each update.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rep_cnt_r <= `REP_ZERO;
		end else if (upd_now) begin
			rep_cnt_r <= rep_val;
		end else if (wrap) begin
			rep_cnt_r <= rep_cnt_r - `REP_ONE;
		end
	end

	// Run flag: started by software or trigger, stopped by software or
	// at the end of a single pulse.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
		end else if (cnt_start || (slave_mode == SM_TRIGGER && trig_rise)) begin
			run_r <= 1'b1;
		end else if (cnt_stop || (one_pulse && wrap && upd_now)) begin
			run_r <= 1'b0;
		end
	end

	// Update, trigger, break and link pulses, one cycle each.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			upd_evt <= 1'b0;
			trg_evt <= 1'b0;
			brk_evt <= 1'b0;
			link_trig_out <= 1'b0;
			adc_trig <= 1'b0;
		end else begin
			upd_evt <= upd_now;
			trg_evt <= ((slave_mode == SM_RESET || slave_mode == SM_TRIGGER)
				&& trig_rise) || (slave_mode == SM_GATED && trig_edge)
				|| hall_chg;
			brk_evt <= rose(brk_s, hist[`SY_BRK]);
			link_trig_out <= upd_now;
			adc_trig <= tick && (cnt_r == adc_pos);
		end
	end

	// Current limit: a high trigger clears the references until the next
	// update; the set wins over the clear in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clr_r <= 1'b0;
		end else if (ref_clear_en && trig_lvl) begin
			clr_r <= 1'b1;
		end else if (upd_now) begin
			clr_r <= 1'b0;
		end
	end

	// Break drops the main enable; software may re-arm once it is gone.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			moe_r <= 1'b0;
		end else if (brk_s) begin
			moe_r <= 1'b0;
		end else if (moe_set) begin
			moe_r <= 1'b1;
		end
	end

	assign out_live = moe_r & ~halted;
	assign moe_state = moe_r;
	assign cnt_value = cnt_r;

	genvar i;
	generate
		for (i = 0; i < `NCH; i++) begin : g_ch
			// Capture, compare match and reference waveform of one channel.
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					ocref_r[i] <= 1'b0;
					cap_val[i] <= `CNT_ZERO;
					cc_evt[i] <= 1'b0;
				end else begin
					cc_evt[i] <= 1'b0;
					case (ch_mode[i])
						CH_CAPTURE: begin
							ocref_r[i] <= 1'b0;
							if (rose(ch_s[i], ch_p[i]) || (i == 0 && hall_chg)) begin
								cap_val[i] <= cnt_r;
								cc_evt[i] <= 1'b1;
							end
						end
						CH_COMPARE: begin
							if (tick && cnt_r == ch_val[i]) begin
								ocref_r[i] <= ~ocref_r[i];
								cc_evt[i] <= 1'b1;
							end
						end
						CH_PWM: begin
							ocref_r[i] <= (cnt_r < ch_val[i]);
							cc_evt[i] <= tick && (cnt_r == ch_val[i]);
						end
						default: ocref_r[i] <= 1'b0;
					endcase
				end
			end

			assign ref_eff[i] = ocref_r[i] & ~clr_r;

			if (i < `NCP) begin : g_pair
				dead_time_unit u_dt (
					.clk_sys(clk_sys),
					.rst_n(rst_n),
					.ref_in(ref_eff[i]),
					.dead(dead_time),
					.out_p(dt_p[i]),
					.out_n(dt_n[i])
				);

				// Pair drive: waveform when live, else reset or known state.
				always_ff @(posedge clk_sys or negedge rst_n) begin
					if (!rst_n) begin
						pwm_out[i] <= 1'b0;
						pwm_oe[i] <= 1'b0;
						pwmn_out[i] <= 1'b0;
						pwmn_oe[i] <= 1'b0;
					end else if (out_live) begin
						pwm_out[i] <= dt_p[i];
						pwmn_out[i] <= dt_n[i];
						pwm_oe[i] <= 1'b1;
						pwmn_oe[i] <= 1'b1;
					end else begin
						pwm_out[i] <= brk_known_state & idle_lvl[i];
						pwmn_out[i] <= brk_known_state & idle_lvl_n[i];
						pwm_oe[i] <= brk_known_state;
						pwmn_oe[i] <= brk_known_state;
					end
				end
			end else begin : g_single
				// Single output without a complement.
				always_ff @(posedge clk_sys or negedge rst_n) begin
					if (!rst_n) begin
						pwm_out[i] <= 1'b0;
						pwm_oe[i] <= 1'b0;
					end else if (out_live) begin
						pwm_out[i] <= ref_eff[i];
						pwm_oe[i] <= 1'b1;
					end else begin
						pwm_out[i] <= brk_known_state & idle_lvl[i];
						pwm_oe[i] <= brk_known_state;
					end
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// >>> hdl/dead_time_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "adv_timer_regs.svh"

// Turns one reference waveform into a complementary pair with a gap.
module dead_time_unit (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Reference and gap length in cycles.
	input wire logic ref_in,
	input wire logic [`DT_W-1:0] dead,
	// Complementary outputs.
	output logic out_p,
	output logic out_n
);

	logic ref_d_r; // Reference one cycle ago.
	logic [`DT_W-1:0] dly_r; // Cycles of gap still to run.

	// On each reference edge both outputs go low for dead cycles, then the
	// new level drives; this keeps both switches of a leg from conducting.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ref_d_r <= 1'b0;
			dly_r <= `DT_ZERO;
			out_p <= 1'b0;
			out_n <= 1'b0;
		end else begin
			ref_d_r <= ref_in;
			if (ref_in != ref_d_r) begin
				dly_r <= dead;
				if (dead == `DT_ZERO) begin
					out_p <= ref_in;
					out_n <= ~ref_in;
				end else begin
					out_p <= 1'b0;
					out_n <= 1'b0;
				end
			end else if (dly_r != `DT_ZERO) begin
				dly_r <= dly_r - `DT_ONE;
				if (dly_r == `DT_ONE) begin
					out_p <= ref_d_r;
					out_n <= ~ref_d_r;
				end
			end else begin
				out_p <= ref_d_r;
				out_n <= ~ref_d_r;
			end
		end
	end

endmodule
`default_nettype wire
